// *** src/logic_cell_pkg.sv ***
// Shared constants, types and configuration carriers of the logic cell unit.
package logic_cell_pkg;

   // ==========================================================
   // Geometry
   localparam int NUM_CELLS   = 3;
   localparam int IN_PER_CELL = 4;
   localparam int NUM_IO      = 12;
   localparam int LUT_W       = 16;
   localparam int SETTLE_W    = 8;
   localparam int SEL_W       = 5;

   // ==========================================================
   // Source selector codes
   localparam logic [SEL_W-1:0] SEL_CONST_ZERO = 5'h00;
   localparam logic [SEL_W-1:0] SEL_INPUT_BASE = 5'h01;
   localparam logic [SEL_W-1:0] SEL_INPUT_LAST = 5'h0C;
   localparam logic [SEL_W-1:0] SEL_OUTPUT_BASE = 5'h0D;
   localparam logic [SEL_W-1:0] SEL_OUTPUT_LAST = 5'h18;

   // ==========================================================
   // Values after reset and the level of a forced output
   localparam logic [NUM_IO-1:0]   RESET_MASK   = 12'h000;
   localparam logic [SETTLE_W-1:0] RESET_COUNT  = 8'h00;
   localparam logic                FORCED_LEVEL = 1'b0;

   // ==========================================================
   // Force release timing
   typedef enum logic [1:0] {
      REL_ON_DEASSERT = 2'b00,
      REL_NEXT_RISE   = 2'b01,
      REL_NEXT_FALL   = 2'b10,
      REL_ANY_EDGE    = 2'b11
   } release_timing_t;

   // ==========================================================
   // Per-output configuration
   typedef struct packed {
      logic [LUT_W-1:0]           lut;
      logic [SETTLE_W-1:0]        high_settle_count;
      logic [SETTLE_W-1:0]        low_settle_count;
      logic                       output_inversion;
      logic [IN_PER_CELL-1:0]     force_source_mask;
      release_timing_t            force_release_timing;
   } output_cfg_t;

   typedef struct packed {
      logic lut_event;
      logic force_event;
      logic forced;
   } slice_event_t;

endpackage

// *** src/output_slice.sv ***
// One cell output: rise and fall filter, force handling, polarity, enable.
`timescale 1ns/10ps
module output_slice
   import logic_cell_pkg::*;
(
   // Clock and reset
   input  wire logic                   clk,
   input  wire logic                   rst_n,
   // Control
   input  wire logic                   run,
   input  wire logic                   enable,
   input  wire logic                   raw_lut,
   input  wire logic                   force_any,
   input  wire logic_cell_pkg::output_cfg_t cfg,
   // Results
   output      logic                   value_q,
   output      logic_cell_pkg::slice_event_t events
);
   import logic_cell_pkg::*;

   logic                raw_prev_q, raw_prev_d;
   logic                filt_q, filt_d;
   logic [SETTLE_W-1:0] cnt_q, cnt_d;
   logic                forced_q, forced_d;
   logic                fprev_q, fprev_d;
   logic                value_d;
   logic                release_ok;
   logic [SETTLE_W-1:0] need;

   // ==========================================================
   // Next state
   always_comb begin
      raw_prev_d = raw_prev_q;
      filt_d     = filt_q;
      cnt_d      = cnt_q;
      forced_d   = forced_q;
      fprev_d    = fprev_q;
      value_d    = value_q;
      release_ok = 1'b0;
      need = raw_lut ? cfg.high_settle_count : cfg.low_settle_count;
      if (run) begin
         raw_prev_d = raw_lut;
         fprev_d    = force_any;
         // A change is taken once it has stood the set number of cycles.
         if (raw_lut != filt_q) begin
            if (cnt_q + 8'h01 >= need) begin // see [R3] see [R4]
               filt_d = raw_lut;
               cnt_d  = RESET_COUNT;
            end else begin
               cnt_d = cnt_q + 8'h01;
            end
         end else begin
            cnt_d = RESET_COUNT;
         end
         unique case (cfg.force_release_timing) // see [R22]
            REL_ON_DEASSERT: release_ok = 1'b1;
            REL_NEXT_RISE:   release_ok = filt_d & ~filt_q;
            REL_NEXT_FALL:   release_ok = ~filt_d & filt_q;
            REL_ANY_EDGE:    release_ok = filt_d ^ filt_q;
         endcase
         if (force_any) begin
            forced_d = 1'b1;
         end else if (release_ok) begin
            forced_d = 1'b0;
         end
         if (!enable) begin // see [R9]
            value_d = 1'b0;
         end else if (forced_d) begin
            value_d = FORCED_LEVEL;
         end else begin
            value_d = filt_d ^ cfg.output_inversion; // see [R10]
         end
      end
      events.lut_event   = run & raw_lut & ~raw_prev_q; // see [R2]
      events.force_event = run & force_any & ~fprev_q;
      events.forced      = forced_q;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         raw_prev_q <= 1'b0;
         filt_q     <= 1'b0;
         cnt_q      <= RESET_COUNT;
         forced_q   <= 1'b0;
         fprev_q    <= 1'b0;
         value_q    <= 1'b0;
      end else begin
         raw_prev_q <= raw_prev_d;
         filt_q     <= filt_d;
         cnt_q      <= cnt_d;
         forced_q   <= forced_d;
         fprev_q    <= fprev_d;
         value_q    <= value_d;
      end
   end

   // ==========================================================
   // Checks
   a_disabled_low: assert property (@(posedge clk) disable iff (!rst_n)
      (run && !enable) |=> !value_q) // see [R9]
      else $error("disabled output is not low");
   a_stall_hold: assert property (@(posedge clk) disable iff (!rst_n)
      !run |=> $stable(value_q) && $stable(filt_q)) // see [R1]
      else $error("output moved while stopped");
   a_force_low: assert property (@(posedge clk) disable iff (!rst_n)
      (run && enable && force_any) |=> value_q == FORCED_LEVEL)
      else $error("forced output not at forced level");
   a_rise_wait: assert property (@(posedge clk) disable iff (!rst_n)
      (run && $rose(filt_q)) |-> $past(raw_lut)) // see [R3]
      else $error("filter rose without a high input");

endmodule

// *** src/logic_cell_unit.sv ***
// Top of the logic cell unit: three cells of four inputs and four outputs.
//
// Function
// [R1] Unit evaluates, filters and raises events only while its clock enable is high.
// [R2] Each output is a lookup table of its cell's inputs; set bit raises event.
// [R3] Output rises only after filtered value stays high the configured cycle count.
// [R4] Output falls only after filtered value stays low the configured cycle count.
// [R5] Each cell input takes its value from a software-programmed source selector.
// [R6] Selector offers constant zero, unit inputs 0..11 and unit outputs 0..11.
// [R7] Per-input substitute enable replaces the selected source by a software value.
// [R8] Each cell input holds its own substitute value, applied while enabled.
// [R9] Each output has an enable; a disabled output drives low.
// [R10] Each output may be passed unchanged or inverted.
// [R11] Per-output debug bit keeps that output running while the chip is halted.
// [R12] Lookup event raises a DMA request when its DMA enable is set.
// [R13] Force event raises a DMA request when its DMA enable is set.
// [R14] Lookup event raises an interrupt request when its interrupt enable is set.
// [R15] Force event raises an interrupt request when its interrupt enable is set.
// [R16] Lookup flags latch per output; software clears exactly the masked flags.
// [R17] Force flags latch per output; software clears exactly the masked flags.
// [R18] Present cell input values read as one mask, bit cell*4+index.
// [R19] Present cell output values read as one mask, same arrangement.
// [R20] Forced outputs read as a mask; each output masks which force inputs act.
// [R21] Twelve force inputs, four per cell, each with optional inversion.
// [R22] Each output has a programmable force release timing.
// [R23] After reset outputs are low and every event flag and request is clear.
`timescale 1ns/10ps
module logic_cell_unit
   import logic_cell_pkg::*;
(
   // Clock and reset
   input  wire logic                        CORE_CLK,
   input  wire logic                        RST_N,
   // Module clock gate and debug
   input  wire logic                        MODULE_CLK_EN,
   input  wire logic                        DEBUG_HALT,
   input  wire logic [logic_cell_pkg::NUM_IO-1:0] DEBUG_RUN,
   // Pins
   input  wire logic [logic_cell_pkg::NUM_IO-1:0] UNIT_IN,
   input  wire logic [logic_cell_pkg::NUM_IO-1:0] FORCE_IN,
   output      logic [logic_cell_pkg::NUM_IO-1:0] UNIT_OUT,
   // Input configuration
   input  wire logic [logic_cell_pkg::NUM_IO-1:0][logic_cell_pkg::SEL_W-1:0]
                                             INPUT_SELECT,
   input  wire logic [logic_cell_pkg::NUM_IO-1:0] INPUT_SUBSTITUTE_ON,
   input  wire logic [logic_cell_pkg::NUM_IO-1:0] INPUT_SUBSTITUTE_VALUE,
   input  wire logic [logic_cell_pkg::NUM_IO-1:0] FORCE_INVERT,
   // Output configuration
   input  wire logic_cell_pkg::output_cfg_t [logic_cell_pkg::NUM_IO-1:0]
                                             OUTPUT_CFG,
   input  wire logic [logic_cell_pkg::NUM_IO-1:0] OUTPUT_ENABLE,
   // Event enables
   input  wire logic [logic_cell_pkg::NUM_IO-1:0] LUT_DMA_EN,
   input  wire logic [logic_cell_pkg::NUM_IO-1:0] FORCE_DMA_EN,
   input  wire logic [logic_cell_pkg::NUM_IO-1:0] LUT_IRQ_EN,
   input  wire logic [logic_cell_pkg::NUM_IO-1:0] FORCE_IRQ_EN,
   // Flag clearing, one-cycle masks
   input  wire logic [logic_cell_pkg::NUM_IO-1:0] LUT_FLAG_CLEAR,
   input  wire logic [logic_cell_pkg::NUM_IO-1:0] FORCE_FLAG_CLEAR,
   // Status
   output      logic [logic_cell_pkg::NUM_IO-1:0] INPUT_STATE,
   output      logic [logic_cell_pkg::NUM_IO-1:0] FORCED_STATE,
   output      logic [logic_cell_pkg::NUM_IO-1:0] LUT_FLAG,
   output      logic [logic_cell_pkg::NUM_IO-1:0] FORCE_FLAG,
   // Requests
   output      logic [logic_cell_pkg::NUM_IO-1:0] LUT_DMA_REQ,
   output      logic [logic_cell_pkg::NUM_IO-1:0] FORCE_DMA_REQ,
   output      logic                        LUT_IRQ,
   output      logic                        FORCE_IRQ
);
   import logic_cell_pkg::*;

   // ==========================================================
   // Pin synchronisers
   logic [NUM_IO-1:0] in_meta_q, in_sync_q;
   logic [NUM_IO-1:0] frc_meta_q, frc_sync_q;

   always_ff @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
         in_meta_q  <= RESET_MASK;
         in_sync_q  <= RESET_MASK;
         frc_meta_q <= RESET_MASK;
         frc_sync_q <= RESET_MASK;
      end else begin
         in_meta_q  <= UNIT_IN;
         in_sync_q  <= in_meta_q;
         frc_meta_q <= FORCE_IN;
         frc_sync_q <= frc_meta_q;
      end
   end

   // ==========================================================
   // Cell input selection
   logic [NUM_IO-1:0] cell_in;
   logic [NUM_IO-1:0] out_val;
   logic [NUM_IO-1:0] force_eff;
   logic [NUM_IO-1:0] run;

   always_comb begin
      logic [SEL_W-1:0] sel;
      logic             src;
      sel = SEL_CONST_ZERO;
      src = 1'b0;
      for (int i = 0; i < NUM_IO; i++) begin
         sel = INPUT_SELECT[i];
         // Codes above the last output read as constant zero.
         if (sel >= SEL_INPUT_BASE && sel <= SEL_INPUT_LAST) begin // see [R6]
            src = in_sync_q[4'(sel - SEL_INPUT_BASE)];
         end else if (sel >= SEL_OUTPUT_BASE && sel <= SEL_OUTPUT_LAST) begin
            src = out_val[4'(sel - SEL_OUTPUT_BASE)];
         end else begin
            src = 1'b0;
         end
         // see [R5] see [R7] see [R8]
         cell_in[i] = INPUT_SUBSTITUTE_ON[i] ? INPUT_SUBSTITUTE_VALUE[i]
                                             : src;
      end
   end

   assign force_eff = frc_sync_q ^ FORCE_INVERT; // see [R21]

   // Debug halt only stops outputs whose debug bit is clear.
   always_comb begin
      for (int o = 0; o < NUM_IO; o++) begin
         run[o] = MODULE_CLK_EN & (~DEBUG_HALT | DEBUG_RUN[o]); // see [R1] see [R11]
      end
   end

   // ==========================================================
   // Output slices
   slice_event_t [NUM_IO-1:0] ev;
   logic         [NUM_IO-1:0] raw_lut;
   logic         [NUM_IO-1:0] force_any;

   for (genvar o = 0; o < NUM_IO; o++) begin : g_out
      localparam int CELL = o / IN_PER_CELL;
      logic [IN_PER_CELL-1:0] idx;
      assign idx          = cell_in[CELL*IN_PER_CELL +: IN_PER_CELL];
      assign raw_lut[o]   = OUTPUT_CFG[o].lut[idx]; // see [R2]
      assign force_any[o] = |(OUTPUT_CFG[o].force_source_mask &
                     force_eff[CELL*IN_PER_CELL +: IN_PER_CELL]); // see [R20]
      output_slice u_slice (
         .clk       (CORE_CLK),
         .rst_n     (RST_N),
         .run       (run[o]),
         .enable    (OUTPUT_ENABLE[o]),
         .raw_lut   (raw_lut[o]),
         .force_any (force_any[o]),
         .cfg       (OUTPUT_CFG[o]),
         .value_q   (out_val[o]),
         .events    (ev[o])
      );
   end

   assign UNIT_OUT = out_val; // see [R19]

   // ==========================================================
   // Event flags and requests
   logic [NUM_IO-1:0] lut_ev, frc_ev, forced;
   logic [NUM_IO-1:0] lut_flag_q, lut_flag_d, frc_flag_q, frc_flag_d;
   logic [NUM_IO-1:0] lut_dma_q, lut_dma_d, frc_dma_q, frc_dma_d;
   logic [NUM_IO-1:0] in_state_q, in_state_d, forced_q, forced_d;
   logic              lut_irq_q, lut_irq_d, frc_irq_q, frc_irq_d;

   always_comb begin
      for (int o = 0; o < NUM_IO; o++) begin
         lut_ev[o] = ev[o].lut_event;
         frc_ev[o] = ev[o].force_event;
         forced[o] = ev[o].forced;
      end
      // A new event wins over a clear in the same cycle.
      lut_flag_d = (lut_flag_q & ~LUT_FLAG_CLEAR) | lut_ev;   // see [R16]
      frc_flag_d = (frc_flag_q & ~FORCE_FLAG_CLEAR) | frc_ev; // see [R17]
      lut_dma_d  = lut_ev & LUT_DMA_EN;                       // see [R12]
      frc_dma_d  = frc_ev & FORCE_DMA_EN;                     // see [R13]
      lut_irq_d  = |(lut_flag_d & LUT_IRQ_EN);                // see [R14]
      frc_irq_d  = |(frc_flag_d & FORCE_IRQ_EN);              // see [R15]
      in_state_d = MODULE_CLK_EN ? cell_in : in_state_q;      // see [R18]
      forced_d   = forced;                                    // see [R20]
   end

   always_ff @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
         lut_flag_q <= RESET_MASK; // see [R23]
         frc_flag_q <= RESET_MASK;
         lut_dma_q  <= RESET_MASK;
         frc_dma_q  <= RESET_MASK;
         in_state_q <= RESET_MASK;
         forced_q   <= RESET_MASK;
         lut_irq_q  <= 1'b0;
         frc_irq_q  <= 1'b0;
      end else begin
         lut_flag_q <= lut_flag_d;
         frc_flag_q <= frc_flag_d;
         lut_dma_q  <= lut_dma_d;
         frc_dma_q  <= frc_dma_d;
         in_state_q <= in_state_d;
         forced_q   <= forced_d;
         lut_irq_q  <= lut_irq_d;
         frc_irq_q  <= frc_irq_d;
      end
   end

   assign LUT_FLAG      = lut_flag_q;
   assign FORCE_FLAG    = frc_flag_q;
   assign LUT_DMA_REQ   = lut_dma_q;
   assign FORCE_DMA_REQ = frc_dma_q;
   assign LUT_IRQ       = lut_irq_q;
   assign FORCE_IRQ     = frc_irq_q;
   assign INPUT_STATE   = in_state_q;
   assign FORCED_STATE  = forced_q;

   // ==========================================================
   // Checks
   a_lut_flag_set: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      (lut_ev != 0) |=> ((LUT_FLAG & $past(lut_ev)) == $past(lut_ev))) // see [R16]
      else $error("lookup event did not set its flag");
   a_lut_flag_clr: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      1'b1 |=> ((LUT_FLAG & ~$past(LUT_FLAG_CLEAR) & ~$past(lut_ev))
               == ($past(LUT_FLAG) & ~$past(LUT_FLAG_CLEAR)
                   & ~$past(lut_ev)))) // see [R16]
      else $error("lookup flag changed outside its clear mask");
   a_frc_flag_set: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      (frc_ev != 0) |=> ((FORCE_FLAG & $past(frc_ev)) == $past(frc_ev))) // see [R17]
      else $error("force event did not set its flag");
   a_lut_dma_req: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      ((lut_ev & LUT_DMA_EN) != 0) |=> (LUT_DMA_REQ != 0)) // see [R12]
      else $error("lookup event gave no dma request");
   a_frc_dma_req: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      (FORCE_DMA_REQ != 0) |-> ($past(frc_ev & FORCE_DMA_EN) == FORCE_DMA_REQ)) // see [R13]
      else $error("force dma request without an enabled event");
   a_lut_irq_out: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      ((lut_flag_d & LUT_IRQ_EN) != 0) |=> LUT_IRQ) // see [R14]
      else $error("lookup interrupt missing");
   a_frc_irq_out: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      FORCE_IRQ |-> ($past(frc_flag_d & FORCE_IRQ_EN) != 0)) // see [R15]
      else $error("force interrupt without an enabled flag");
   // Flags may still be cleared while gated, so only clear-free cycles count.
   a_gate_quiet: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      (!MODULE_CLK_EN && (LUT_FLAG_CLEAR | FORCE_FLAG_CLEAR) == '0)
         |=> $stable({LUT_FLAG, FORCE_FLAG})) // see [R1]
      else $error("flag moved while the module clock is gated");

endmodule

// *** tb/far_side.sv ***
// Far-side model: pin drivers, flag-clear strobes and DMA request counters.
`timescale 1ns/10ps
module far_side
   import logic_cell_pkg::*;
(
   // Clock and reset
   input  wire logic                              clk,
   input  wire logic                              rst_n,
   // Bench commands
   input  wire logic [logic_cell_pkg::NUM_IO-1:0] pin_cmd,
   input  wire logic [logic_cell_pkg::NUM_IO-1:0] force_cmd,
   input  wire logic [logic_cell_pkg::NUM_IO-1:0] lclr_cmd,
   input  wire logic [logic_cell_pkg::NUM_IO-1:0] fclr_cmd,
   // Toward the unit
   output logic      [logic_cell_pkg::NUM_IO-1:0] unit_in_q,
   output logic      [logic_cell_pkg::NUM_IO-1:0] force_in_q,
   output logic      [logic_cell_pkg::NUM_IO-1:0] lut_clr_q,
   output logic      [logic_cell_pkg::NUM_IO-1:0] force_clr_q,
   // DMA side
   input  wire logic [logic_cell_pkg::NUM_IO-1:0] lut_dma_req,
   input  wire logic [logic_cell_pkg::NUM_IO-1:0] force_dma_req,
   output int                                     lut_dma_cnt_q,
   output int                                     force_dma_cnt_q
);
   import logic_cell_pkg::*;

   logic [NUM_IO-1:0] lclr_prev_q;
   logic [NUM_IO-1:0] fclr_prev_q;

   // Pins move just after an edge, like any synchronous source would.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         unit_in_q       <= '0;
         force_in_q      <= '0;
         lut_clr_q       <= '0;
         force_clr_q     <= '0;
         lclr_prev_q     <= '0;
         fclr_prev_q     <= '0;
         lut_dma_cnt_q   <= 0;
         force_dma_cnt_q <= 0;
      end else begin
         unit_in_q       <= pin_cmd;
         force_in_q      <= force_cmd;
         // A held command must clear once only, so strobe on its edge.
         lut_clr_q       <= lclr_cmd & ~lclr_prev_q;
         force_clr_q     <= fclr_cmd & ~fclr_prev_q;
         lclr_prev_q     <= lclr_cmd;
         fclr_prev_q     <= fclr_cmd;
         lut_dma_cnt_q   <= lut_dma_cnt_q + $countones(lut_dma_req);
         force_dma_cnt_q <= force_dma_cnt_q + $countones(force_dma_req);
      end
   end
endmodule

// *** tb/tb.sv ***
// Self-checking testbench of the logic cell unit.
`timescale 1ns/10ps
module tb;
   import logic_cell_pkg::*;

   logic                         clk, rst_n, clk_en, dbg_halt;
   logic [NUM_IO-1:0]            dbg_run, pin_cmd, force_cmd, lclr, fclr;
   logic [NUM_IO-1:0]            unit_in, force_in, lut_clr, force_clr;
   logic [NUM_IO-1:0][SEL_W-1:0] sel;
   logic [NUM_IO-1:0]            sub_on, sub_val, f_inv, out_en;
   logic [NUM_IO-1:0]            ldma_en, fdma_en, lirq_en, firq_en;
   output_cfg_t [NUM_IO-1:0]     cfg;
   logic [NUM_IO-1:0]            unit_out, in_st, forced_st;
   logic [NUM_IO-1:0]            lut_flag, force_flag, ldma, fdma;
   logic                         lirq, firq;
   int                           lcnt, fcnt, fail_count, cmp_count;
   int                           l0, f0, n;

   // ==========================================================
   // Clock, design and far side
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   logic_cell_unit dut (.CORE_CLK(clk), .RST_N(rst_n), .MODULE_CLK_EN(clk_en),
      .DEBUG_HALT(dbg_halt), .DEBUG_RUN(dbg_run), .UNIT_IN(unit_in),
      .FORCE_IN(force_in), .UNIT_OUT(unit_out), .INPUT_SELECT(sel),
      .INPUT_SUBSTITUTE_ON(sub_on), .INPUT_SUBSTITUTE_VALUE(sub_val),
      .FORCE_INVERT(f_inv), .OUTPUT_CFG(cfg), .OUTPUT_ENABLE(out_en),
      .LUT_DMA_EN(ldma_en), .FORCE_DMA_EN(fdma_en), .LUT_IRQ_EN(lirq_en),
      .FORCE_IRQ_EN(firq_en), .LUT_FLAG_CLEAR(lut_clr),
      .FORCE_FLAG_CLEAR(force_clr), .INPUT_STATE(in_st),
      .FORCED_STATE(forced_st), .LUT_FLAG(lut_flag), .FORCE_FLAG(force_flag),
      .LUT_DMA_REQ(ldma), .FORCE_DMA_REQ(fdma), .LUT_IRQ(lirq),
      .FORCE_IRQ(firq));

   far_side peer (.clk(clk), .rst_n(rst_n), .pin_cmd(pin_cmd),
      .force_cmd(force_cmd), .lclr_cmd(lclr), .fclr_cmd(fclr),
      .unit_in_q(unit_in), .force_in_q(force_in), .lut_clr_q(lut_clr),
      .force_clr_q(force_clr), .lut_dma_req(ldma), .force_dma_req(fdma),
      .lut_dma_cnt_q(lcnt), .force_dma_cnt_q(fcnt));

   // ==========================================================
   // Shared tasks
   task automatic chk(input logic [23:0] seen, exp, input string what);
      cmp_count++;
      if (seen !== exp) begin
         fail_count++;
         $display("[FAIL] %0t %s: saw %h expected %h", $time, what, seen, exp);
      end
   endtask

   task automatic tick(input int k);
      repeat (k) @(posedge clk);
      #1;
   endtask

   // Counts edges until an output shows the level; bounded by 40 cycles.
   task automatic wait_out(input int i, input logic lv, output int k);
      k = 0;
      while (unit_out[i] !== lv && k < 40) begin
         @(posedge clk);
         #1;
         k++;
      end
      chk(unit_out[i], lv, "output level");
   endtask

   task automatic clear(input logic [11:0] l, f);
      @(posedge clk);
      lclr <= l;
      fclr <= f;
      @(posedge clk);
      lclr <= '0;
      fclr <= '0;
      tick(3);
   endtask

   task automatic results();
      $display("checks %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   // ==========================================================
   // Scenarios
   task automatic t_reset();
      chk({unit_out, forced_st}, '0, "outputs after reset");
      chk(lut_flag | force_flag | ldma | fdma, '0, "flags");
      chk({lirq, firq}, '0, "irq after reset");
   endtask

   task automatic t_lut();
      @(posedge clk);
      cfg[0].lut <= 16'h0002;
      cfg[1].lut <= 16'h0002;
      sel[0] <= SEL_INPUT_BASE;
      out_en[1:0] <= 2'b11;
      ldma_en[0] <= 1'b1;
      lirq_en[0] <= 1'b1;
      tick(2);
      pin_cmd[0] <= 1'b1;
      wait_out(0, 1'b1, l0);
      tick(1);
      chk(unit_out, 12'h003, "output mask");
      chk(lut_flag, 12'h003, "lookup flags");
      chk(lcnt[11:0], 12'h001, "lookup dma count");
      chk(lirq, 1'b1, "lookup irq");
      clear(12'h001, '0);
      chk(lut_flag, 12'h002, "masked clear");
      chk(lirq, 1'b0, "irq follows flag");
      clear(12'h002, '0);
      @(posedge clk);
      pin_cmd[0] <= 1'b0;
      wait_out(0, 1'b0, f0);
      // Model register, two synchroniser stages and the output register.
      chk({l0[11:0], f0[11:0]}, 24'h004004, "pin latency");
   endtask

   task automatic t_filter();
      @(posedge clk);
      cfg[0].high_settle_count <= 8'h06;
      cfg[0].low_settle_count <= 8'h04;
      tick(2);
      pin_cmd[0] <= 1'b1;
      wait_out(0, 1'b1, n);
      chk(n[11:0], 12'(l0 + 5), "rise settle cycles");
      tick(2);
      pin_cmd[0] <= 1'b0;
      wait_out(0, 1'b0, n);
      chk(n[11:0], 12'(f0 + 3), "fall settle cycles");
      clear(12'h003, '0);
   endtask

   task automatic t_sub();
      @(posedge clk);
      sub_val[5] <= 1'b1;
      sub_on[6:5] <= 2'b11;
      sel[6] <= SEL_INPUT_BASE + 5'h01;
      pin_cmd[1] <= 1'b1;
      tick(5);
      chk(in_st & 12'h060, 12'h020, "substitutes");
      sub_on[6:5] <= 2'b00;
      tick(5);
      chk(in_st & 12'h060, 12'h040, "sources restored");
   endtask

   task automatic t_invert();
      @(posedge clk);
      cfg[2].output_inversion <= 1'b1;
      tick(6);
      chk(unit_out[2], 1'b0, "disabled output");
      out_en[2] <= 1'b1;
      wait_out(2, 1'b1, n);
   endtask

   task automatic t_select();
      @(posedge clk);
      pin_cmd <= 12'h5A2;
      for (int k = 0; k < 27; k++) begin
         @(posedge clk);
         sel[4] <= 5'(k);
         tick(5);
         if (k >= 1 && k <= 12)
            chk(in_st[4], pin_cmd[k-1], "input source");
         else
            chk(in_st[4], 1'(k == 15), "output or zero");
      end
   endtask

   task automatic t_force();
      @(posedge clk);
      cfg[2].force_source_mask <= 4'b0100;
      fdma_en[2] <= 1'b1;
      firq_en[2] <= 1'b1;
      force_cmd[1] <= 1'b1;
      tick(6);
      chk(forced_st, '0, "unselected force input");
      force_cmd[2] <= 1'b1;
      wait_out(2, FORCED_LEVEL, n);
      tick(2);
      chk(forced_st, 12'h004, "forced mask");
      chk(force_flag, 12'h004, "force flag");
      chk(fcnt[11:0], 12'h001, "force dma count");
      chk(firq, 1'b1, "force irq");
      force_cmd[2] <= 1'b0;
      wait_out(2, 1'b1, n);
      tick(2);
      chk({forced_st, force_flag}, 24'h000004, "sticky");
      clear('0, 12'h004);
      chk({force_flag, 11'h000, firq}, '0, "flag cleared");
      f_inv[2] <= 1'b1;
      wait_out(2, FORCED_LEVEL, n);
      f_inv[2] <= 1'b0;
      wait_out(2, 1'b1, n);
      // Each edge-released mode holds the force until the filtered edge.
      for (int m = 1; m < 4; m++) begin
         cfg[2].force_release_timing <= release_timing_t'(m);
         f_inv[2] <= 1'b1;
         tick(3);
         f_inv[2] <= 1'b0;
         tick(4);
         chk(forced_st[2], 1'b1, "force held");
         cfg[2].lut <= ~cfg[2].lut;
         tick(3);
         chk(forced_st[2], 1'b0, "force released");
      end
   endtask

   task automatic t_gate();
      @(posedge clk);
      clk_en <= 1'b0;
      pin_cmd[0] <= 1'b1;
      tick(15);
      chk(unit_out[0] | lut_flag[0], 1'b0, "gated clock frozen");
      clk_en <= 1'b1;
      wait_out(0, 1'b1, n);
      dbg_halt <= 1'b1;
      pin_cmd[0] <= 1'b0;
      tick(15);
      chk(unit_out[0], 1'b1, "halted output frozen");
      dbg_run[0] <= 1'b1;
      wait_out(0, 1'b0, n);
      dbg_halt <= 1'b0;
   endtask

   // ==========================================================
   // Main sequence and watchdog
   initial begin
      fail_count = 0;
      cmp_count = 0;
      rst_n = 1'b0;
      clk_en = 1'b1;
      dbg_halt = 1'b0;
      {dbg_run, pin_cmd, force_cmd, lclr, fclr, sub_on, sub_val} = '0;
      {f_inv, out_en, ldma_en, fdma_en, lirq_en, firq_en} = '0;
      sel = '0;
      cfg = '0;
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      tick(1);
      t_reset();
      t_lut();
      t_filter();
      t_sub();
      t_invert();
      t_select();
      t_force();
      t_gate();
      results();
   end

   // The scenarios need well under two thousand cycles.
   initial begin
      repeat (20000) @(posedge clk);
      fail_count++;
      results();
   end
endmodule
